/* wrs_pkg.sv */
`default_nettype none

package wrs_pkg;

    // Core clock and watchdog oscillator periods
    localparam int CORE_PERIOD_NS = 20;
    localparam int OSC_PERIOD_NS = 1000;
    localparam int OSC_DIV = OSC_PERIOD_NS / CORE_PERIOD_NS;
    localparam int DIV_W = 6;

    // Shortest time-out is two to this power oscillator ticks
    localparam int BASE_LOG2 = 14;

    // Length of the protected-change window in core cycles
    localparam logic [2:0] CE_CYCLES = 3'h4;

    // Register indices and their byte addresses
    localparam logic [7:0] STS_IDX = 8'h35;
    localparam logic [7:0] CTL_IDX = 8'h36;
    localparam logic [7:0] STS_ADDR = {STS_IDX[5:0], 2'b00};
    localparam logic [7:0] CTL_ADDR = {CTL_IDX[5:0], 2'b00};

    // Reset values
    localparam logic [7:0] STS_RESET = 8'h01;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] rsv;
        logic ce;
        logic en;
        logic [2:0] sel;
    } wrs_ctl_t;

    typedef struct packed {
        logic [2:0] rsv;
        logic scan;
        logic wd;
        logic bo;
        logic ext;
        logic por;
    } wrs_sts_t;

endpackage : wrs_pkg

`default_nettype wire

/* wrs_watchdog.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module wrs_watchdog
    import wrs_pkg::*;
#(
    parameter int WDT_BASE_LOG2 = BASE_LOG2
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic ALWAYS_ON_FUSE_I,
    input wire logic RESTART_I,
    input wire logic BROWNOUT_RST_I,
    input wire logic EXTERNAL_RST_I,
    input wire logic SCAN_RST_I,
    output logic WDT_RESET_O,
    output logic WDT_ENABLED_O,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    localparam int CNT_W = WDT_BASE_LOG2 + 8;
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(OSC_DIV - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic fuse_ff;
    logic [DIV_W-1:0] div_ff;
    logic tick_ff;
    logic [CNT_W-1:0] wdt_cnt_ff;
    logic en_ff;
    logic [2:0] sel_ff;
    logic [2:0] ce_cnt_ff;
    wrs_sts_t flags_ff;
    logic wdt_rst_ff;

    logic aw_have_ff;
    logic w_have_ff;
    logic awready_ff;
    logic wready_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [7:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic wr_go;
    logic ctl_wr;
    logic sts_wr;
    logic ce_open;
    logic timeout;
    logic chip_rst;
    wrs_ctl_t wr_ctl;
    wrs_ctl_t rd_ctl;
    wrs_sts_t set_s;
    logic [7:0] keep_mask;
    logic [7:0] nxt_rdata;
    logic [1:0] nxt_rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic wrs_mapped(input logic [7:0] a);
        return (a == STS_ADDR) || (a == CTL_ADDR);
    endfunction : wrs_mapped

    function automatic logic [CNT_W-1:0] wrs_limit(input logic [2:0] sel);
        return (CNT_W'(1) << (WDT_BASE_LOG2 + int'(sel))) - CNT_W'(1);
    endfunction : wrs_limit

    ////////////////////////////////////////////////////////////////////////////
    // Fuse capture and oscillator-rate enable

    // Fuse is a static strap, caught while reset is held
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            fuse_ff <= ALWAYS_ON_FUSE_I;
        end
    end

    // One-cycle tick per oscillator period; all logic stays in one domain
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == DIV_MAX) begin
            div_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + DIV_W'(1);
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog counter and time-out

    // Reaching or passing the limit counts, so a shortened period after a select change still fires
    assign timeout = en_ff && tick_ff && (wdt_cnt_ff >= wrs_limit(sel_ff));
    assign chip_rst = timeout || BROWNOUT_RST_I || EXTERNAL_RST_I || SCAN_RST_I;

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || chip_rst || RESTART_I || !en_ff) begin
            wdt_cnt_ff <= '0;
        end else if (tick_ff) begin
            wdt_cnt_ff <= wdt_cnt_ff + CNT_W'(1);
        end
    end

    // Counter clears on the time-out, so the pulse lasts one cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            wdt_rst_ff <= 1'b0;
        end else begin
            wdt_rst_ff <= timeout;
        end
    end

    assign WDT_RESET_O = wdt_rst_ff;
    assign WDT_ENABLED_O = en_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Control register with protected changes

    assign wr_ctl = wrs_ctl_t'(wdata_ff);
    assign ce_open = (ce_cnt_ff != 3'h0);
    assign wr_go = aw_have_ff && w_have_ff;
    assign ctl_wr = wr_go && wstrb0_ff && (awaddr_ff == CTL_ADDR);
    assign sts_wr = wr_go && wstrb0_ff && (awaddr_ff == STS_ADDR);

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            en_ff <= ALWAYS_ON_FUSE_I;
            sel_ff <= SEL_RESET;
            ce_cnt_ff <= 3'h0;
        end else if (chip_rst) begin
            en_ff <= fuse_ff;
            sel_ff <= SEL_RESET;
            ce_cnt_ff <= 3'h0;
        end else begin
            if (ce_open) begin
                ce_cnt_ff <= ce_cnt_ff - 3'h1;
            end
            if (ctl_wr) begin
                if (wr_ctl.ce && wr_ctl.en) begin
                    ce_cnt_ff <= CE_CYCLES;
                    en_ff <= 1'b1;
                    if (ce_open) begin
                        sel_ff <= wr_ctl.sel;
                    end
                end else if (ce_open) begin
                    sel_ff <= wr_ctl.sel;
                    en_ff <= fuse_ff || wr_ctl.en;
                    ce_cnt_ff <= 3'h0;
                end else begin
                    en_ff <= en_ff || wr_ctl.en;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset source flags

    always_comb begin
        set_s = '0;
        set_s.scan = SCAN_RST_I;
        set_s.wd = timeout;
        set_s.bo = BROWNOUT_RST_I;
        set_s.ext = EXTERNAL_RST_I;
        keep_mask = sts_wr ? {3'h0, wdata_ff[4:0]} : 8'h1F;
    end

    // A set in the cycle of a clearing write wins
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            flags_ff <= STS_RESET;
        end else begin
            flags_ff <= (flags_ff & keep_mask) | set_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus write channels

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            awready_ff <= 1'b1;
            aw_have_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (S_AXI_AWVALID && awready_ff) begin
            awready_ff <= 1'b0;
            aw_have_ff <= 1'b1;
            awaddr_ff <= S_AXI_AWADDR;
        end else if (wr_go) begin
            aw_have_ff <= 1'b0;
        end else if (bvalid_ff && S_AXI_BREADY) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            wready_ff <= 1'b1;
            w_have_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else if (S_AXI_WVALID && wready_ff) begin
            wready_ff <= 1'b0;
            w_have_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA[7:0];
            wstrb0_ff <= S_AXI_WSTRB[0];
        end else if (wr_go) begin
            w_have_ff <= 1'b0;
        end else if (bvalid_ff && S_AXI_BREADY) begin
            wready_ff <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wrs_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY = wready_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Bus read channel

    always_comb begin
        rd_ctl = '0;
        rd_ctl.ce = ce_open;
        rd_ctl.en = en_ff || fuse_ff;
        rd_ctl.sel = sel_ff;
        rd_ctl.rsv = 3'h0;
        if (S_AXI_ARADDR == STS_ADDR) begin
            nxt_rdata = flags_ff;
            nxt_rresp = RESP_OKAY;
        end else if (S_AXI_ARADDR == CTL_ADDR) begin
            nxt_rdata = rd_ctl;
            nxt_rresp = RESP_OKAY;
        end else begin
            nxt_rdata = 8'h00;
            nxt_rresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rresp_ff <= RESP_OKAY;
        end else if (S_AXI_ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = {24'h000000, rdata_ff};
    assign S_AXI_RRESP = rresp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CORE_CLK_I);
    endclocking

    default disable iff (RST_I);

    tick_period_a: assert property (
        tick_ff |-> ##50 tick_ff
    ) else $error("oscillator tick period wrong");

    restart_clear_a: assert property (
        RESTART_I |=> (wdt_cnt_ff == '0)
    ) else $error("restart did not clear counter");

    disabled_clear_a: assert property (
        !en_ff |=> (wdt_cnt_ff == '0)
    ) else $error("disabled watchdog kept counting");

    timeout_pulse_a: assert property (
        timeout |=> WDT_RESET_O ##1 !WDT_RESET_O
    ) else $error("time-out pulse not one cycle");

    timeout_limit_a: assert property (
        (en_ff && tick_ff && wdt_cnt_ff == ({CNT_W{1'b1}} >> (4'h8 - {1'b0, sel_ff}))) |-> timeout
    ) else $error("time-out missed at limit");

    early_timeout_a: assert property (
        timeout |-> (wdt_cnt_ff >= ({CNT_W{1'b1}} >> (4'h8 - {1'b0, sel_ff})))
    ) else $error("time-out before limit");

    level2_enable_a: assert property (
        fuse_ff |-> en_ff
    ) else $error("level 2 watchdog disabled");

    level1_enable_a: assert property (
        (ctl_wr && wr_ctl.en && !chip_rst) |=> en_ff
    ) else $error("enable write ignored");

    window_open_a: assert property (
        (ctl_wr && wr_ctl.ce && wr_ctl.en && !chip_rst) ##1 (!ctl_wr && !chip_rst) [*4]
        |-> ($past(ce_open, 3) && ce_open) ##1 !ce_open
    ) else $error("change window not four cycles");

    enable_hold_a: assert property (
        (ctl_wr && !ce_open && en_ff && !chip_rst) |=> en_ff
    ) else $error("enable cleared outside window");

    select_hold_a: assert property (
        (ctl_wr && !ce_open && !chip_rst) |=> $stable(sel_ff)
    ) else $error("select changed outside window");

    wd_flag_a: assert property (
        timeout |=> flags_ff.wd
    ) else $error("watchdog flag not set");

    por_keep_a: assert property (
        (flags_ff.por && !sts_wr) |=> flags_ff.por
    ) else $error("power-on flag lost");

    rsv_zero_a: assert property (
        (rvalid_ff && S_AXI_RRESP == RESP_OKAY) |-> (S_AXI_RDATA[31:5] == 27'h0)
    ) else $error("reserved bits read nonzero");

    timeout_c: cover property (timeout);
    window_c: cover property (ctl_wr && ce_open && !wr_ctl.ce);
    flag_clear_c: cover property (sts_wr && flags_ff.por ##1 !flags_ff.por);
    restart_c: cover property (en_ff && RESTART_I && wdt_cnt_ff != '0);

endmodule : wrs_watchdog

`default_nettype wire

/* wrs_watchdog_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end

module wrs_watchdog_tb
    import wrs_pkg::*;
();
    // Short time-out keeps the run small: code 0 gives two ticks
    localparam int TB_LOG2 = 1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fuse = 1'b0;
    logic restart = 1'b0;
    logic bo = 1'b0;
    logic ext = 1'b0;
    logic scan = 1'b0;
    logic wdt_rst;
    logic wdt_en;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] rd;
    logic [1:0] rsp;
    int n_fail = 0;
    int tests_run = 0;
    int n_rst = 0;
    int n;
    int c;
    int k;

    always #(CORE_PERIOD_NS / 2) clk = ~clk;
    always @(posedge clk) if (wdt_rst === 1'b1) n_rst <= n_rst + 1;

    wrs_watchdog #(.WDT_BASE_LOG2(TB_LOG2)) wrs_watchdog_i (
        .CORE_CLK_I(clk), .RST_I(rst), .ALWAYS_ON_FUSE_I(fuse), .RESTART_I(restart),
        .BROWNOUT_RST_I(bo), .EXTERNAL_RST_I(ext), .SCAN_RST_I(scan),
        .WDT_RESET_O(wdt_rst), .WDT_ENABLED_O(wdt_en),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Waits for the answer however long it takes; only the watchdog process ends a hang
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata[7:0];
        rsp = rresp;
    endtask : rdr

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        rdr(a);
        `CHK(rd, e)
        `CHK(rsp, RESP_OKAY)
    endtask : chk_rd

    task automatic seq(input logic en, input logic [2:0] sel);
        wr(CTL_ADDR, 8'h18);
        wr(CTL_ADDR, {4'h0, en, sel});
    endtask : seq

    task automatic por(input logic f);
        rst <= 1'b1;
        fuse <= f;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : por

    // Source 0 brown-out, 1 external pin, 2 scan, 3 restart
    task automatic pulse(input int s);
        bo <= (s == 0);
        ext <= (s == 1);
        scan <= (s == 2);
        restart <= (s == 3);
        @(posedge clk);
        {bo, ext, scan, restart} <= 4'h0;
        @(posedge clk);
    endtask : pulse

    // Counts edges until the time-out pulse, then checks it lasts one cycle
    task automatic wait_to();
        c = 0;
        while (wdt_rst !== 1'b1 && c < 20000) begin
            @(posedge clk);
            c++;
        end
        @(posedge clk);
        `CHK(wdt_rst, 1'b0)
    endtask : wait_to

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        por(1'b0);
        chk_rd(STS_ADDR, STS_RESET);
        chk_rd(CTL_ADDR, 8'h00);
        `CHK(wdt_en, 1'b0)
        rdr(8'h00);
        `CHK({rsp, rd}, {RESP_SLVERR, 8'h00})
        wr(8'h00, 8'h08);
        `CHK(rsp, RESP_SLVERR)
        $display("test reset and map done");

        wr(CTL_ADDR, 8'h08);
        chk_rd(CTL_ADDR, 8'h08);
        `CHK(wdt_en, 1'b1)
        wr(CTL_ADDR, 8'h00);
        chk_rd(CTL_ADDR, 8'h08);
        wr(CTL_ADDR, 8'hEF);
        chk_rd(CTL_ADDR, 8'h08);
        wr(CTL_ADDR, 8'h18);
        chk_rd(CTL_ADDR, 8'h18);
        repeat (6) @(posedge clk);
        chk_rd(CTL_ADDR, 8'h08);
        wr(CTL_ADDR, 8'h01);
        chk_rd(CTL_ADDR, 8'h08);
        seq(1'b0, 3'h5);
        chk_rd(CTL_ADDR, 8'h05);
        `CHK(wdt_en, 1'b0)
        n = n_rst;
        repeat (400) @(posedge clk);
        `CHK(n_rst, n)
        $display("test level 1 sequence done");

        seq(1'b1, 3'h0);
        for (k = 0; k < 10; k++) begin
            pulse(3);
            repeat (30) @(posedge clk);
        end
        `CHK(n_rst, n)
        for (k = 0; k < 4; k++) begin
            seq(1'b1, k[2:0]);
            pulse(3);
            wait_to();
            `CHK(c >= ((1 << (TB_LOG2 + k)) - 1) * OSC_DIV - 5, 1'b1)
            `CHK(c <= (1 << (TB_LOG2 + k)) * OSC_DIV + 10, 1'b1)
            chk_rd(STS_ADDR, 8'h09);
            chk_rd(CTL_ADDR, 8'h00);
            wr(STS_ADDR, 8'h01);
        end
        chk_rd(STS_ADDR, 8'h01);
        $display("test time-out done");

        wr(STS_ADDR, 8'h00);
        chk_rd(STS_ADDR, 8'h00);
        pulse(0);
        chk_rd(STS_ADDR, 8'h04);
        pulse(1);
        chk_rd(STS_ADDR, 8'h06);
        pulse(2);
        chk_rd(STS_ADDR, 8'h16);
        wr(STS_ADDR, 8'h1B);
        chk_rd(STS_ADDR, 8'h12);
        wr(STS_ADDR, 8'h00);
        chk_rd(STS_ADDR, 8'h00);
        wr(CTL_ADDR, 8'h08);
        pulse(1);
        `CHK(wdt_en, 1'b0)
        chk_rd(STS_ADDR, 8'h02);
        por(1'b0);
        chk_rd(STS_ADDR, 8'h01);
        $display("test flags done");

        por(1'b1);
        `CHK(wdt_en, 1'b1)
        chk_rd(CTL_ADDR, 8'h08);
        wr(CTL_ADDR, 8'h00);
        chk_rd(CTL_ADDR, 8'h08);
        seq(1'b0, 3'h2);
        chk_rd(CTL_ADDR, 8'h0A);
        `CHK(wdt_en, 1'b1)
        wr(CTL_ADDR, 8'h03);
        chk_rd(CTL_ADDR, 8'h0A);
        pulse(3);
        wait_to();
        `CHK(c >= ((1 << (TB_LOG2 + 2)) - 1) * OSC_DIV - 5, 1'b1)
        chk_rd(CTL_ADDR, 8'h08);
        `CHK(wdt_en, 1'b1)
        $display("test level 2 done");
        test_done();
    end

    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule : wrs_watchdog_tb

`default_nettype wire
